/* hdl/lpps_defines.svh */
// Register map, reset values and timing counts of the panel control block
`ifndef LPPS_DEFINES_SVH
`define LPPS_DEFINES_SVH
// Register byte offsets
`define LPPS_OFF_CTRL   8'h00
`define LPPS_OFF_STAT   8'h04
`define LPPS_OFF_MASK   8'h08
`define LPPS_OFF_FBNEXT 8'h0C
`define LPPS_OFF_FBACT  8'h10
`define LPPS_OFF_HTIM   8'h14
`define LPPS_OFF_VTIM   8'h18
`define LPPS_OFF_VSYN   8'h1C
`define LPPS_OFF_PON    8'h20
`define LPPS_OFF_POFF   8'h24
`define LPPS_OFF_DIV    8'h28
`define LPPS_OFF_STATE  8'h2C
// Control bits
`define LPPS_CTRL_PWR    0
`define LPPS_CTRL_EXTCLK 1
// Status bits: frame end, power-on done, power-off done
`define LPPS_ST_FEND  0
`define LPPS_ST_PON   1
`define LPPS_ST_POFF  2
`define LPPS_ST_W     3
// Reset values: 648/480 dots, sync 1 eighth at 71, 648/640 lines
`define LPPS_RST_HTIM 32'h4701_3C51
`define LPPS_RST_VTIM 32'h0280_0288
`define LPPS_RST_VSYN 32'h0286_0001
`define LPPS_RST_PON  32'h0001_0102
`define LPPS_RST_POFF 32'h0001_0105
`define LPPS_RST_DIV  32'h0000_0001
// Pixel address step per dot (one 32-bit word)
`define LPPS_PIX_STEP 32'h0000_0004
// Least reset low time after supply settle, in ns, and in clk cycles
`define LPPS_CLK_NS       100
`define LPPS_RST_LOW_NS   20000
`define LPPS_RST_LOW_CYC  ((`LPPS_RST_LOW_NS + `LPPS_CLK_NS - 1) / `LPPS_CLK_NS)
`endif

/* hdl/lpps_pkg.sv */
// Types shared by the panel control block
package lpps_pkg;
  // Power sequencer states
  typedef enum logic [2:0] {
    LPPS_OFF   = 3'b000,
    LPPS_ON_A  = 3'b001,
    LPPS_ON_B  = 3'b010,
    LPPS_ON_C  = 3'b011,
    LPPS_RUN   = 3'b100,
    LPPS_OFF_A = 3'b101,
    LPPS_OFF_B = 3'b110,
    LPPS_OFF_C = 3'b111
  } lpps_pwr_e;
  // Avalon word types
  typedef logic [31:0] lpps_word_t;
  typedef logic [7:0]  lpps_addr_t;
endpackage : lpps_pkg

/* hdl/lpps_top.sv */
// Panel timing, power sequencing and plane switch with Avalon-MM registers
//
// Overview of operation
// - Supply output high powers panel, low cuts.
// - Dot clock from own clock or external.
// - First power-on step lasts programmed frames.
// - Sync and pixels run before init-enable.
// - Reset stays low at least 20 us; here it stays low for the programmed frames of steps A and B.
// - Reset released before init-enable rises.
// - Off: wait frames, stop sync, reset low.
// - Later off steps each wait programmed frames.
// - New address displays from following frame end.
// - Raster defaults to 480 by 640 portrait.
// - Horizontal timing in units of eight dots.
// - Line total and active given in eighths.
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`include "lpps_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lpps_top #(
  parameter int DIV_W = 16                    // Dot divider width
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Avalon-MM slave
  input  wire lpps_pkg::lpps_addr_t avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire lpps_pkg::lpps_word_t avs_writedata,
  output var  lpps_pkg::lpps_word_t avs_readdata,
  output var  logic                 avs_waitrequest,
  // Interrupt
  output var  logic                 irq,
  // Pixel fetch
  output var  lpps_pkg::lpps_word_t pixel_addr_out,
  input  wire logic [17:0]          pixel_data_in,
  // Panel pins
  input  wire logic                 external_lcd_clock_in,
  output var  logic [17:0]          pixel_data_out,
  output var  logic                 dot_clock_out,
  output var  logic                 line_sync_out,
  output var  logic                 frame_sync_out,
  output var  logic                 display_enable_out,
  output var  logic                 panel_init_enable_out,
  output var  logic                 panel_reset_out,
  output var  logic                 panel_supply_ctrl_out
);
  import lpps_pkg::*;

  // Refuse a divider width outside 2..32
  if (DIV_W < 2 || DIV_W > 32) begin : g_chk
    $error("DIV_W must be 2..32");
  end

  // Registers seen by software
  lpps_word_t ctrl_q, mask_q, fbnext_q, fbact_q;
  lpps_word_t htim_q, vtim_q, vsyn_q, pon_q, poff_q, div_q;
  logic [`LPPS_ST_W-1:0] stat_q;              // Sticky events
  logic                  wait_q;              // Waitrequest flop
  lpps_word_t            rdata_q;             // Read data flop
  // Timing state
  logic [DIV_W-1:0] dcnt_q;                   // Internal divider
  logic             dclk_q;                   // Internal dot level
  logic [2:0]       ext_q;                    // Ext clock sync + edge
  logic [10:0]      hcnt_q;                   // Dot within line
  logic [11:0]      vcnt_q;                   // Line within frame
  logic             fend_q;                   // Frame end pulse
  lpps_pwr_e        pwr_q, pwr_d;             // Power sequencer
  logic [7:0]       fcnt_q;                   // Frames in current step
  logic             irq_q;

  // Bus decode
  wire        req     = avs_read | avs_write;
  wire        wr_go   = avs_write & ~wait_q;  // Write lands at ack edge
  wire [31:0] bemask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire        wr_ctrl = wr_go & (avs_address == `LPPS_OFF_CTRL);
  wire        wr_stat = wr_go & (avs_address == `LPPS_OFF_STAT);
  wire        wr_mask = wr_go & (avs_address == `LPPS_OFF_MASK);
  wire        wr_fbn  = wr_go & (avs_address == `LPPS_OFF_FBNEXT);
  wire        wr_htim = wr_go & (avs_address == `LPPS_OFF_HTIM);
  wire        wr_vtim = wr_go & (avs_address == `LPPS_OFF_VTIM);
  wire        wr_vsyn = wr_go & (avs_address == `LPPS_OFF_VSYN);
  wire        wr_pon  = wr_go & (avs_address == `LPPS_OFF_PON);
  wire        wr_poff = wr_go & (avs_address == `LPPS_OFF_POFF);
  wire        wr_div  = wr_go & (avs_address == `LPPS_OFF_DIV);

  // Byte-lane merge of a register with write data
  function automatic lpps_word_t merge(input lpps_word_t old);
    merge = (old & ~bemask) | (avs_writedata & bemask);
  endfunction : merge

  // Read mux; unmapped offsets read zero
  wire lpps_word_t rmux =
    (avs_address == `LPPS_OFF_CTRL)   ? ctrl_q :
    (avs_address == `LPPS_OFF_STAT)   ? {29'h0, stat_q} :
    (avs_address == `LPPS_OFF_MASK)   ? mask_q :
    (avs_address == `LPPS_OFF_FBNEXT) ? fbnext_q :
    (avs_address == `LPPS_OFF_FBACT)  ? fbact_q :
    (avs_address == `LPPS_OFF_HTIM)   ? htim_q :
    (avs_address == `LPPS_OFF_VTIM)   ? vtim_q :
    (avs_address == `LPPS_OFF_VSYN)   ? vsyn_q :
    (avs_address == `LPPS_OFF_PON)    ? pon_q :
    (avs_address == `LPPS_OFF_POFF)   ? poff_q :
    (avs_address == `LPPS_OFF_DIV)    ? div_q :
    (avs_address == `LPPS_OFF_STATE)  ? {29'h0, pwr_q} : 32'h0000_0000;

  // One wait cycle, then ack for one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= ~(req & wait_q);
      if (avs_read & wait_q) rdata_q <= rmux;
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q   <= 32'h0000_0000;
      mask_q   <= 32'h0000_0000;
      fbnext_q <= 32'h0000_0000;
      htim_q   <= `LPPS_RST_HTIM;
      vtim_q   <= `LPPS_RST_VTIM;
      vsyn_q   <= `LPPS_RST_VSYN;
      pon_q    <= `LPPS_RST_PON;
      poff_q   <= `LPPS_RST_POFF;
      div_q    <= `LPPS_RST_DIV;
    end else begin
      if (wr_ctrl) ctrl_q   <= merge(ctrl_q) & 32'h0000_0003;
      if (wr_mask) mask_q   <= merge(mask_q) & 32'h0000_0007;
      if (wr_fbn)  fbnext_q <= merge(fbnext_q);
      if (wr_htim) htim_q   <= merge(htim_q);
      if (wr_vtim) vtim_q   <= merge(vtim_q) & 32'h0FFF_0FFF;
      if (wr_vsyn) vsyn_q   <= merge(vsyn_q) & 32'h0FFF_0FFF;
      if (wr_pon)  pon_q    <= merge(pon_q) & 32'h00FF_FFFF;
      if (wr_poff) poff_q   <= merge(poff_q) & 32'h00FF_FFFF;
      if (wr_div)  div_q    <= merge(div_q);
    end
  end

  // Timing fields, horizontal ones in units of eight dots
  wire [10:0] h_tot  = {htim_q[7:0], 3'b000};
  wire [10:0] h_act  = {htim_q[15:8], 3'b000};
  wire [10:0] hs_beg = {htim_q[31:24], 3'b000};
  wire [10:0] hs_end = hs_beg + {htim_q[23:16], 3'b000};
  wire [11:0] v_tot  = vtim_q[11:0];
  wire [11:0] v_act  = vtim_q[27:16];
  wire [11:0] vs_beg = vsyn_q[27:16];
  wire [11:0] vs_end = vs_beg + vsyn_q[11:0];

  // Dot source: own divider or synchronised external clock
  wire use_ext   = ctrl_q[`LPPS_CTRL_EXTCLK];
  wire [DIV_W-1:0] half = div_q[DIV_W-1:0];
  wire div_wrap  = (dcnt_q >= half);
  wire int_tick  = div_wrap & dclk_q;          // Falling internal edge
  wire ext_tick  = ~ext_q[1] & ext_q[2];       // Falling external edge
  wire dot_tick  = use_ext ? ext_tick : int_tick;
  wire dot_level = use_ext ? ext_q[1] : (dclk_q ^ div_wrap); // Next level

  // Divider and external clock synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dcnt_q <= '0;
      dclk_q <= 1'b0;
      ext_q  <= 3'b000;
    end else begin
      dcnt_q <= div_wrap ? '0 : dcnt_q + 1'b1;
      if (div_wrap) dclk_q <= ~dclk_q;
      ext_q  <= {ext_q[1:0], external_lcd_clock_in};
    end
  end

  // Raster counters, run while the supply is on
  wire run_tg  = (pwr_q != LPPS_OFF);
  wire h_last  = (hcnt_q >= h_tot - 11'd1);
  wire v_last  = (vcnt_q >= v_tot - 12'd1);
  wire fend_d  = run_tg & dot_tick & h_last & v_last;
  wire in_act  = (hcnt_q < h_act) & (vcnt_q < v_act);
  wire in_hs   = (hcnt_q >= hs_beg) & (hcnt_q < hs_end);
  wire in_vs   = (vcnt_q >= vs_beg) & (vcnt_q < vs_end);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hcnt_q <= 11'h000;
      vcnt_q <= 12'h000;
      fend_q <= 1'b0;
    end else begin
      fend_q <= fend_d;
      if (!run_tg) begin
        hcnt_q <= 11'h000;
        vcnt_q <= 12'h000;
      end else if (dot_tick) begin
        hcnt_q <= h_last ? 11'h000 : hcnt_q + 11'd1;
        if (h_last) vcnt_q <= v_last ? 12'h000 : vcnt_q + 12'd1;
      end
    end
  end

  // Period of the current power step, zero read as one frame
  wire [7:0] per =
    (pwr_q == LPPS_ON_A)  ? pon_q[7:0]   :
    (pwr_q == LPPS_ON_B)  ? pon_q[15:8]  :
    (pwr_q == LPPS_ON_C)  ? pon_q[23:16] :
    (pwr_q == LPPS_OFF_A) ? poff_q[7:0]  :
    (pwr_q == LPPS_OFF_B) ? poff_q[15:8] : poff_q[23:16];
  wire step_done = fend_q & ({1'b0, fcnt_q} + 9'd1 >= {1'b0, per});
  wire pwr_req   = ctrl_q[`LPPS_CTRL_PWR];

  // Power sequencer next state
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      LPPS_OFF:   if (pwr_req) pwr_d = LPPS_ON_A;
      LPPS_ON_A:  if (step_done) pwr_d = LPPS_ON_B;
      LPPS_ON_B:  if (step_done) pwr_d = LPPS_ON_C;
      LPPS_ON_C:  if (step_done) pwr_d = LPPS_RUN;
      LPPS_RUN:   if (!pwr_req && fend_q) pwr_d = LPPS_OFF_A;
      LPPS_OFF_A: if (step_done) pwr_d = LPPS_OFF_B;
      LPPS_OFF_B: if (step_done) pwr_d = LPPS_OFF_C;
      LPPS_OFF_C: if (step_done) pwr_d = LPPS_OFF;
      default:    pwr_d = LPPS_OFF;
    endcase
  end

  // Step outputs: sync runs from step B until off step A ends
  wire sync_on = (pwr_d == LPPS_ON_B) | (pwr_d == LPPS_ON_C) |
                 (pwr_d == LPPS_RUN) | (pwr_d == LPPS_OFF_A);
  wire rst_hi  = (pwr_d == LPPS_ON_C) | (pwr_d == LPPS_RUN) |
                 (pwr_d == LPPS_OFF_A);
  wire pon_ev  = (pwr_q == LPPS_ON_C) & (pwr_d == LPPS_RUN);
  wire poff_ev = (pwr_q == LPPS_OFF_C) & (pwr_d == LPPS_OFF);

  // Sequencer state, frame count and panel power pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_q                 <= LPPS_OFF;
      fcnt_q                <= 8'h00;
      panel_supply_ctrl_out <= 1'b0;
      panel_reset_out       <= 1'b0;
      panel_init_enable_out <= 1'b0;
    end else begin
      pwr_q  <= pwr_d;
      fcnt_q <= (pwr_d != pwr_q) ? 8'h00 : fcnt_q + {7'h00, fend_q};
      panel_supply_ctrl_out <= (pwr_d != LPPS_OFF);
      panel_reset_out       <= rst_hi;
      panel_init_enable_out <= (pwr_d == LPPS_RUN);
    end
  end

  // Sync, enable, dot clock and pixel pins
  wire sync_run = (pwr_q == LPPS_ON_B) | (pwr_q == LPPS_ON_C) |
                  (pwr_q == LPPS_RUN) | (pwr_q == LPPS_OFF_A);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_sync_out      <= 1'b0;
      frame_sync_out     <= 1'b0;
      display_enable_out <= 1'b0;
      pixel_data_out     <= 18'h0_0000;
      dot_clock_out      <= 1'b0;
    end else begin
      dot_clock_out <= sync_on & dot_level;
      if (!sync_on) begin
        line_sync_out      <= 1'b0;
        frame_sync_out     <= 1'b0;
        display_enable_out <= 1'b0;
        pixel_data_out     <= 18'h0_0000;
      end else if (dot_tick) begin
        line_sync_out      <= ~in_hs;
        frame_sync_out     <= ~in_vs;
        display_enable_out <= in_act;
        pixel_data_out     <= in_act ? pixel_data_in : 18'h0_0000;
      end
    end
  end

  // Plane address: staged write shown from the next frame end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fbact_q        <= 32'h0000_0000;
      pixel_addr_out <= 32'h0000_0000;
    end else if (fend_d) begin
      fbact_q        <= fbnext_q;
      pixel_addr_out <= fbnext_q;
    end else if (dot_tick & sync_run & in_act) begin
      pixel_addr_out <= pixel_addr_out + `LPPS_PIX_STEP;
    end
  end

  // Sticky events, set wins over a write-one clear
  wire [`LPPS_ST_W-1:0] ev_set = {poff_ev, pon_ev, fend_d};
  wire [`LPPS_ST_W-1:0] st_clr = wr_stat ?
                          (avs_writedata[2:0] & bemask[2:0]) : 3'b000;
  wire [`LPPS_ST_W-1:0] stat_d = (stat_q & ~st_clr) | ev_set;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= 3'b000;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= |(stat_d & mask_q[2:0]);
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign irq             = irq_q;

  // Helper counts for the checks below
  logic [15:0] rlow_q;                         // Cycles in step B
  logic [7:0]  power_off_period_c_q;                         // Frames in off step A
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rlow_q <= 16'h0000;
      power_off_period_c_q <= 8'h00;
    end else begin
      rlow_q <= (pwr_q == LPPS_ON_B) ? rlow_q + 16'd1 : 16'h0000;
      power_off_period_c_q <= (pwr_q == LPPS_OFF_A) ? power_off_period_c_q + {7'h00, fend_q} : 8'h00;
    end
  end
  // Checks
  supply_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(panel_supply_ctrl_out) |-> !panel_reset_out &&
      !panel_init_enable_out && !display_enable_out)
    else $error("supply rose with panel already active");
  sync_before_init_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(panel_init_enable_out) |-> $past(sync_run, 2) && sync_run)
    else $error("init rose before sync output ran");
  reset_low_min_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pwr_q == LPPS_ON_B && pwr_d == LPPS_ON_C) |->
      rlow_q >= 16'(`LPPS_RST_LOW_CYC))
    else $error("panel reset released too early");
  reset_before_init_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(panel_init_enable_out) |-> $past(panel_reset_out, 2))
    else $error("init rose before reset release");
  off_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pwr_q == LPPS_OFF_A && pwr_d == LPPS_OFF_B) |->
      fend_q && ({1'b0, power_off_period_c_q} + 9'd1 >= {1'b0, poff_q[7:0]}))
    else $error("sync stopped before off wait elapsed");
  off_order_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(panel_supply_ctrl_out) |-> !panel_reset_out &&
      $past(!line_sync_out && !panel_reset_out, 2))
    else $error("supply cut before reset and sync stopped");
  plane_at_end_a: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(fbact_q) |-> $past(fend_d))
    else $error("plane address changed mid frame");
  hsync_eighths_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(line_sync_out) |-> $past(hcnt_q[2:0]) == 3'd0)
    else $error("line sync not on an eight dot boundary");
  enable_active_a: assert property (@(posedge clk) disable iff (!reset_n)
    display_enable_out |-> panel_supply_ctrl_out && hcnt_q != 11'h000 &&
      hcnt_q <= h_act && vcnt_q < v_act)
    else $error("data enable outside active pixels");
  bus_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus ack not one cycle after request");
  power_on_c: cover property (@(posedge clk) disable iff (!reset_n)
    pon_ev);
  power_off_c: cover property (@(posedge clk) disable iff (!reset_n)
    poff_ev);
  plane_switch_c: cover property (@(posedge clk) disable iff (!reset_n)
    $changed(fbact_q) && panel_init_enable_out);
endmodule : lpps_top
`default_nettype wire

/* dv/lpps_panel_model.sv */
// Panel-side observer: measures dots, frames and power step timing
`timescale 1ns/1ps
`default_nettype none
module lpps_panel_model (
  // Sampling clock
  input  wire logic        clk,
  // Panel pins
  input  wire logic [17:0] pixel_data_out,
  input  wire logic        dot_clock_out,
  input  wire logic        line_sync_out,
  input  wire logic        frame_sync_out,
  input  wire logic        display_enable_out,
  input  wire logic        panel_init_enable_out,
  input  wire logic        panel_reset_out,
  input  wire logic        panel_supply_ctrl_out,
  // Expected pixel and measured figures
  input  wire logic [17:0] exp_pix,
  output var  int          hsync_dots,
  output var  int          active_dots,
  output var  int          pix_bad,
  output var  int          dots_pre_init,
  output var  int          sup_to_dot,
  output var  int          rst_low,
  output var  int          fr_on,
  output var  int          fr_off,
  output var  int          rst_to_sup,
  output var  logic        order_bad
);
  logic dck_q  = 1'b0;  // Previous pin levels
  logic rst_q  = 1'b0;
  logic init_q = 1'b0;
  logic sup_q  = 1'b0;
  logic vs_q   = 1'b0;
  int   hs_cnt, act_cnt, frames, f_mark, clk_cnt, t_sup, t_rst;
  // Panel latches on the rising dot edge
  always @(posedge clk) begin
    dck_q   <= dot_clock_out;
    rst_q   <= panel_reset_out;
    init_q  <= panel_init_enable_out;
    sup_q   <= panel_supply_ctrl_out;
    vs_q    <= frame_sync_out;
    clk_cnt <= clk_cnt + 1;
    if (dot_clock_out && !dck_q) begin
      if (!line_sync_out) hs_cnt <= hs_cnt + 1;
      else if (hs_cnt != 0) begin
        hsync_dots <= hs_cnt;
        hs_cnt     <= 0;
      end
      if (display_enable_out) begin
        act_cnt <= act_cnt + 1;
        if (pixel_data_out !== exp_pix) pix_bad <= pix_bad + 1;
      end
      if (sup_q && !panel_init_enable_out) begin
        if (dots_pre_init == 0) sup_to_dot <= clk_cnt - t_sup;
        dots_pre_init <= dots_pre_init + 1;
      end
    end
    // Frame start seen as falling frame sync while out of reset
    if (!frame_sync_out && vs_q) begin
      active_dots <= act_cnt;
      act_cnt     <= 0;
      if (panel_reset_out) frames <= frames + 1;
    end
    if (panel_supply_ctrl_out && !sup_q) t_sup <= clk_cnt;
    if (panel_reset_out && !rst_q) begin
      rst_low   <= clk_cnt - t_sup;
      f_mark    <= frames;
      order_bad <= panel_init_enable_out;
    end
    if (panel_init_enable_out && !init_q) fr_on <= frames - f_mark;
    if (!panel_init_enable_out && init_q) f_mark <= frames;
    if (!panel_reset_out && rst_q) begin
      fr_off <= frames - f_mark;
      t_rst  <= clk_cnt;
    end
    if (!panel_supply_ctrl_out && sup_q) rst_to_sup <= clk_cnt - t_rst;
  end
endmodule : lpps_panel_model
`default_nettype wire

/* dv/tb_lpps_top.sv */
// Self-checking bench of the panel control block
`include "lpps_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_lpps_top;
  import lpps_pkg::*;
  localparam logic [17:0] PIX = 18'h2_a5c3;  // Fixed pixel word
  localparam lpps_addr_t OFFS [10] = '{`LPPS_OFF_CTRL, `LPPS_OFF_MASK,
    `LPPS_OFF_FBNEXT, `LPPS_OFF_HTIM, `LPPS_OFF_VTIM, `LPPS_OFF_VSYN,
    `LPPS_OFF_PON, `LPPS_OFF_POFF, `LPPS_OFF_DIV, `LPPS_OFF_STATE};
  localparam lpps_word_t RV [10] = '{32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, `LPPS_RST_HTIM, `LPPS_RST_VTIM, `LPPS_RST_VSYN,
    `LPPS_RST_PON, `LPPS_RST_POFF, `LPPS_RST_DIV, 32'h0000_0000};
  logic        clk = 1'b0, reset_n = 1'b0, ext_clk = 1'b0;
  lpps_addr_t  avs_address = 8'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  lpps_word_t  avs_writedata = 32'h0000_0000, avs_readdata, pixel_addr_out;
  logic        avs_waitrequest, irq, dck, lsync, fsync, panel_data_enable_in, init, prst, sup;
  logic [17:0] pixel_data_out;
  logic        order_bad;
  int          hsd, actd, pixb, dpre, s2d, rlow, fon, foff, r2s;
  int          n_mismatch, samples_checked, cyc;
  // Clocks: system 100 ns, external dot source 800 ns, unrelated phase
  initial forever #50 clk = ~clk;
  initial begin
    #137;
    forever #400 ext_clk = ~ext_clk;
  end
  lpps_top lpps_top_i (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .pixel_addr_out(pixel_addr_out), .pixel_data_in(PIX),
    .external_lcd_clock_in(ext_clk), .pixel_data_out(pixel_data_out),
    .dot_clock_out(dck), .line_sync_out(lsync), .frame_sync_out(fsync),
    .display_enable_out(panel_data_enable_in), .panel_init_enable_out(init),
    .panel_reset_out(prst), .panel_supply_ctrl_out(sup));
  lpps_panel_model lpps_panel_model_i (.clk(clk),
    .pixel_data_out(pixel_data_out), .dot_clock_out(dck),
    .line_sync_out(lsync), .frame_sync_out(fsync), .display_enable_out(panel_data_enable_in),
    .panel_init_enable_out(init), .panel_reset_out(prst),
    .panel_supply_ctrl_out(sup), .exp_pix(PIX), .hsync_dots(hsd),
    .active_dots(actd), .pix_bad(pixb), .dots_pre_init(dpre),
    .sup_to_dot(s2d), .rst_low(rlow), .fr_on(fon), .fr_off(foff),
    .rst_to_sup(r2s), .order_bad(order_bad));
  // Cycle count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic check(input string nm, input lpps_word_t seen,
                       input lpps_word_t exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input lpps_addr_t a,
                     input lpps_word_t d, output lpps_word_t q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check("bus_ack", n < 20, 1);
  endtask : bus
  task automatic wr(input lpps_addr_t a, input lpps_word_t d);
    lpps_word_t q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input lpps_addr_t a, output lpps_word_t q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask : rd
  task automatic wait_state(input lpps_word_t s);
    lpps_word_t d;
    int n;
    n = 0;
    do begin
      rd(`LPPS_OFF_STATE, d);
      n++;
    end while (d !== s && n < 600);
    check("state", d, s);
  endtask : wait_state
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check("irq_wait", n < 400, 1);
  endtask : wait_irq
  task automatic dot_rise(output int t);
    logic p;
    int n;
    n = 0;
    do begin
      p = dck;
      @(posedge clk);
      n++;
    end while (!(p === 1'b0 && dck === 1'b1) && n < 100);
    t = cyc;
  endtask : dot_rise
  // Reset values, unmapped and read-only places
  task automatic t_regs();
    lpps_word_t d;
    for (int i = 0; i < 10; i++) begin
      rd(OFFS[i], d);
      check("reset_val", d, RV[i]);
    end
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, d);
    check("unmapped", d, 32'h0000_0000);
    wr(`LPPS_OFF_STATE, 32'h0000_0007);
    rd(`LPPS_OFF_STATE, d);
    check("state_ro", d, 32'h0000_0000);
  endtask : t_regs
  // Short raster: 16 dots a line, 8 active, 4 lines, 2 active
  task automatic t_power_on();
    lpps_word_t d;
    wr(`LPPS_OFF_HTIM, 32'h0101_0102);
    wr(`LPPS_OFF_VTIM, 32'h0002_0004);
    wr(`LPPS_OFF_VSYN, 32'h0002_0001);
    wr(`LPPS_OFF_DIV, 32'h0000_0000);
    wr(`LPPS_OFF_PON, 32'h0001_0202);
    wr(`LPPS_OFF_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    check("supply_on", sup, 1);
    check("reset_low", prst, 0);
    wait_state(32'h0000_0004);
    rd(`LPPS_OFF_STAT, d);
    check("pon_done", d & 32'h0000_0002, 32'h0000_0002);
    check("a_frames", s2d >= 256 && s2d <= 264, 1);
    check("rst_hold", rlow - s2d >= 200, 1);
    check("rst_first", order_bad, 0);
    check("c_frames", fon, 1);
    check("sync_first", dpre > 0, 1);
    repeat (300) @(posedge clk);
    check("hsync_dots", hsd, 8);
    check("active_dots", actd, 16);
    check("pixel_map", pixb, 0);
  endtask : t_power_on
  // Frame-end event: sticky, masked, cleared by writing one
  task automatic t_irq();
    lpps_word_t d;
    wr(`LPPS_OFF_MASK, 32'h0000_0001);
    wait_irq();
    wr(`LPPS_OFF_STAT, 32'h0000_0001);
    repeat (5) @(posedge clk);
    check("irq_clear", irq, 0);
    wr(`LPPS_OFF_MASK, 32'h0000_0000);
    repeat (300) @(posedge clk);
    check("irq_masked", irq, 0);
    rd(`LPPS_OFF_STAT, d);
    check("fend_sticky", d & 32'h0000_0001, 32'h0000_0001);
    wr(`LPPS_OFF_STAT, 32'h0000_0007);
  endtask : t_irq
  // Four planes in turn, switched from the frame-end handler
  task automatic t_plane();
    lpps_word_t d, base;
    int n;
    wr(`LPPS_OFF_MASK, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      base = (i + 1) * 32'h0001_0000;
      wait_irq();
      wr(`LPPS_OFF_STAT, 32'h0000_0001);
      repeat (5) @(posedge clk);
      wr(`LPPS_OFF_FBNEXT, base);
      rd(`LPPS_OFF_FBACT, d);
      check("fb_hold", d !== base, 1);
      wait_irq();
      wr(`LPPS_OFF_STAT, 32'h0000_0001);
      rd(`LPPS_OFF_FBACT, d);
      check("fb_new", d, base);
      n = 0;
      while (panel_data_enable_in !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      check("fetch_base", pixel_addr_out[31:16], base[31:16]);
    end
    wr(`LPPS_OFF_MASK, 32'h0000_0000);
  endtask : t_plane
  // Dot clock from own clock, then from the external source
  task automatic t_dot_src();
    int t0, t1;
    dot_rise(t0);
    dot_rise(t1);
    check("int_period", t1 - t0, 2);
    wr(`LPPS_OFF_CTRL, 32'h0000_0003);
    repeat (40) @(posedge clk);
    dot_rise(t0);
    dot_rise(t1);
    check("ext_period", t1 - t0 >= 7 && t1 - t0 <= 9, 1);
    wr(`LPPS_OFF_CTRL, 32'h0000_0001);
  endtask : t_dot_src
  // Power off with default step lengths 5, 1, 1
  task automatic t_power_off();
    lpps_word_t d;
    wr(`LPPS_OFF_CTRL, 32'h0000_0000);
    wait_state(32'h0000_0005);
    check("init_off", init, 0);
    check("supply_held", sup, 1);
    wait_state(32'h0000_0000);
    check("off_a_frames", foff, 5);
    check("off_bc_time", r2s >= 250 && r2s <= 266, 1);
    check("supply_cut", sup, 0);
    check("reset_off", prst, 0);
    check("sync_stop", {dck, lsync, fsync, panel_data_enable_in}, 0);
    rd(`LPPS_OFF_STAT, d);
    check("poff_done", d & 32'h0000_0004, 32'h0000_0004);
  endtask : t_power_off
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_power_on();
    t_irq();
    t_plane();
    t_dot_src();
    t_power_off();
    summarize();
  end
endmodule : tb_lpps_top
`default_nettype wire
